// ===== hw/swl_pkg.sv
`default_nettype none
package swl_pkg;
  // ==========================================================
  // clock
  localparam int CLK_NS = 40;
  localparam int CNT_W = 16;
  localparam int BYTE_W = 8;
  localparam int RX_W = 9;
  localparam int FIFO_DEPTH = 16;
  // command byte bit 7 high means a write with one data byte following
  localparam int WRITE_FLAG_BIT = 7;

  // ==========================================================
  // timing in microseconds
  localparam int DEV_PERIOD_US = 205;
  localparam int DEV_ONE_US = 40;
  localparam int DEV_ZERO_US = 112;
  localparam int RESP_DELAY_US = 400;
  localparam int SAMPLE_US = 65;
  localparam int BREAK_DETECT_US = 160;
  localparam int HOST_PERIOD_US = 200;
  localparam int HOST_ONE_US = 20;
  localparam int HOST_ZERO_US = 112;
  localparam int BREAK_US = 250;
  localparam int RECOVERY_US = 60;
  localparam int TURNAROUND_US = 210;
  localparam int RESP_TIMEOUT_US = 1000;

  // ==========================================================
  // cycle counts, least times rounded up
  function automatic int cyc_up(input int us);
    return (us * 1000 + CLK_NS - 1) / CLK_NS;
  endfunction

  localparam int DEV_PERIOD_CYC = cyc_up(DEV_PERIOD_US);
  localparam int DEV_ONE_CYC = cyc_up(DEV_ONE_US);
  localparam int DEV_ZERO_CYC = cyc_up(DEV_ZERO_US);
  localparam int RESP_DELAY_CYC = cyc_up(RESP_DELAY_US);
  localparam int SAMPLE_CYC = cyc_up(SAMPLE_US);
  localparam int BREAK_DETECT_CYC = cyc_up(BREAK_DETECT_US);
  localparam int HOST_PERIOD_CYC = cyc_up(HOST_PERIOD_US);
  localparam int HOST_ONE_CYC = cyc_up(HOST_ONE_US);
  localparam int HOST_ZERO_CYC = cyc_up(HOST_ZERO_US);
  localparam int BREAK_CYC = cyc_up(BREAK_US);
  localparam int RECOVERY_CYC = cyc_up(RECOVERY_US);
  localparam int TURNAROUND_CYC = cyc_up(TURNAROUND_US);
  localparam int RESP_TIMEOUT_CYC = cyc_up(RESP_TIMEOUT_US);
endpackage
`default_nettype wire

// ===== hw/swl_if.sv
`timescale 1ns/1ns
`default_nettype none
interface swl_if;
  logic host_o;
  logic host_oe;
  logic dev_o;
  logic dev_oe;
  logic line;

  // ==========================================================
  // open-drain wire with pull-up
  assign line = ~((host_oe & ~host_o) | (dev_oe & ~dev_o));

  modport host(output host_o, output host_oe, input line);
  modport dev(output dev_o, output dev_oe, input line);
endinterface
`default_nettype wire

// ===== hw/swl_device.sv
// Behaviour
// - host bit period at least 190 us
// - device bit period 190 to 250 us
// - host one: low 0.5 to 50 us
// - device one: low 32 to 50 us
// - host zero: low 86 to 145 us
// - device zero: low 80 to 145 us
// - reply starts 190 to 950 us later
// - host waits 210 us before next break
`timescale 1ns/1ns
`default_nettype none
module swl_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wr_q, wr_d, rd_q, rd_d;
  logic full_q, full_d, avail_q, avail_d;
  logic do_wr, do_rd;

  // ==========================================================
  // pointers and flags
  always_comb
  begin
    do_wr = in_valid && !full_q;
    do_rd = out_ready && avail_q;
    wr_d = do_wr ? wr_q + 1'b1 : wr_q;
    rd_d = do_rd ? rd_q + 1'b1 : rd_q;
    avail_d = (wr_d != rd_d);
    full_d = (wr_d[AW] != rd_d[AW]) && (wr_d[AW-1:0] == rd_d[AW-1:0]);
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      wr_q <= '0;
      rd_q <= '0;
      full_q <= 1'b0;
      avail_q <= 1'b0;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      full_q <= full_d;
      avail_q <= avail_d;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (do_wr)
    begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  assign in_ready = !full_q;
  assign out_valid = avail_q;
  assign out_data = mem[rd_q[AW-1:0]];
endmodule

module swl_device #(
  parameter int PERIOD_CYC = swl_pkg::DEV_PERIOD_CYC,
  parameter int ONE_CYC = swl_pkg::DEV_ONE_CYC,
  parameter int ZERO_CYC = swl_pkg::DEV_ZERO_CYC,
  parameter int RESP_CYC = swl_pkg::RESP_DELAY_CYC,
  parameter int SAMPLE_CYC = swl_pkg::SAMPLE_CYC,
  parameter int BREAK_DET_CYC = swl_pkg::BREAK_DETECT_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  swl_if.dev link,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [swl_pkg::RX_W-1:0] rx_data,
  input wire logic [swl_pkg::BYTE_W-1:0] resp_byte,
  output logic overrun
);
  import swl_pkg::*;

  localparam logic [CNT_W-1:0] K_PERIOD = CNT_W'(PERIOD_CYC - 1);
  localparam logic [CNT_W-1:0] K_ONE = CNT_W'(ONE_CYC);
  localparam logic [CNT_W-1:0] K_ZERO = CNT_W'(ZERO_CYC);
  localparam logic [CNT_W-1:0] K_RESP = CNT_W'(RESP_CYC - 1);
  localparam logic [CNT_W-1:0] K_SAMPLE = CNT_W'(SAMPLE_CYC);
  localparam logic [CNT_W-1:0] K_BREAK = CNT_W'(BREAK_DET_CYC);

  typedef enum logic [2:0] {
    D_LISTEN = 3'b001,
    D_WAIT = 3'b010,
    D_SEND = 3'b100
  } dev_state_e;

  dev_state_e st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [2:0] nbit_q, nbit_d;
  logic [BYTE_W-1:0] sh_q, sh_d, rx_byte;
  logic arm_q, arm_d, cmd_q, cmd_d, ovr_q, ovr_d, drv_q, drv_d;
  logic s1_q, s2_q, prev_q, fall, push, fifo_ready;

  // ==========================================================
  // line synchroniser and edge detect
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      prev_q <= 1'b1;
    end
    else
    begin
      s1_q <= link.line;
      s2_q <= s1_q;
      prev_q <= s2_q;
    end
  end

  assign fall = prev_q && !s2_q;
  assign rx_byte = {s2_q, sh_q[BYTE_W-1:1]};

  // ==========================================================
  // bit engine
  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    nbit_d = nbit_q;
    sh_d = sh_q;
    arm_d = arm_q;
    cmd_d = cmd_q;
    ovr_d = ovr_q;
    drv_d = 1'b0;
    push = 1'b0;
    case (st_q)
      D_LISTEN:
      begin
        if (fall)
        begin
          cnt_d = '0;
          arm_d = 1'b1;
        end
        else if (cnt_q != '1)
        begin
          cnt_d = cnt_q + 1'b1;
        end
        if (!s2_q && cnt_q == K_BREAK)
        begin
          nbit_d = '0;
          cmd_d = 1'b1;
          arm_d = 1'b0;
        end
        else if (arm_q && cnt_q == K_SAMPLE)
        begin
          arm_d = 1'b0;
          sh_d = rx_byte;
          nbit_d = nbit_q + 1'b1;
          if (nbit_q == 3'd7)
          begin
            push = 1'b1;
            ovr_d = ovr_q | !fifo_ready;
            cmd_d = !(cmd_q && s2_q);
            // a full buffer also cancels the reply to a read, which is then never sent
            if (cmd_q && !s2_q && fifo_ready)
            begin
              st_d = D_WAIT;
              cnt_d = '0;
            end
          end
        end
      end
      D_WAIT:
      begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == K_RESP)
        begin
          st_d = D_SEND;
          cnt_d = '0;
          nbit_d = '0;
          sh_d = resp_byte;
          drv_d = 1'b1;
        end
      end
      D_SEND:
      begin
        cnt_d = cnt_q + 1'b1;
        drv_d = (cnt_q + 1'b1) < (sh_q[0] ? K_ONE : K_ZERO);
        if (cnt_q == K_PERIOD)
        begin
          cnt_d = '0;
          sh_d = {1'b0, sh_q[BYTE_W-1:1]};
          nbit_d = nbit_q + 1'b1;
          drv_d = 1'b1;
          if (nbit_q == 3'd7)
          begin
            st_d = D_LISTEN;
            cnt_d = '1;
            cmd_d = 1'b1;
            arm_d = 1'b0;
            drv_d = 1'b0;
          end
        end
      end
      default:
      begin
        st_d = D_LISTEN;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      st_q <= D_LISTEN;
      cnt_q <= '1;
      nbit_q <= '0;
      sh_q <= '0;
      arm_q <= 1'b0;
      cmd_q <= 1'b1;
      ovr_q <= 1'b0;
      drv_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      nbit_q <= nbit_d;
      sh_q <= sh_d;
      arm_q <= arm_d;
      cmd_q <= cmd_d;
      ovr_q <= ovr_d;
      drv_q <= drv_d;
    end
  end

  // ==========================================================
  // received bytes, tagged with command flag
  swl_fifo #(
    .W(RX_W),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data({cmd_q, rx_byte}),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );

  assign link.dev_o = 1'b0;
  assign link.dev_oe = drv_q;
  assign overrun = ovr_q;
endmodule
`default_nettype wire

// ===== hw/swl_host.sv
`timescale 1ns/1ns
`default_nettype none
module swl_host #(
  parameter int PERIOD_CYC = swl_pkg::HOST_PERIOD_CYC,
  parameter int ONE_CYC = swl_pkg::HOST_ONE_CYC,
  parameter int ZERO_CYC = swl_pkg::HOST_ZERO_CYC,
  parameter int BREAK_CYC = swl_pkg::BREAK_CYC,
  parameter int RECOVERY_CYC = swl_pkg::RECOVERY_CYC,
  parameter int TURN_CYC = swl_pkg::TURNAROUND_CYC,
  parameter int SAMPLE_CYC = swl_pkg::SAMPLE_CYC,
  parameter int TIMEOUT_CYC = swl_pkg::RESP_TIMEOUT_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  swl_if.host link,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [swl_pkg::BYTE_W-1:0] req_cmd,
  input wire logic [swl_pkg::BYTE_W-1:0] req_wdata,
  output logic rd_valid,
  output logic [swl_pkg::BYTE_W-1:0] rd_data,
  output logic rd_timeout
);
  import swl_pkg::*;

  localparam logic [CNT_W-1:0] K_PERIOD = CNT_W'(PERIOD_CYC - 1);
  localparam logic [CNT_W-1:0] K_ONE = CNT_W'(ONE_CYC);
  localparam logic [CNT_W-1:0] K_ZERO = CNT_W'(ZERO_CYC);
  localparam logic [CNT_W-1:0] K_BREAK = CNT_W'(BREAK_CYC - 1);
  localparam logic [CNT_W-1:0] K_RECOV = CNT_W'(RECOVERY_CYC - 1);
  localparam logic [CNT_W-1:0] K_TURN = CNT_W'(TURN_CYC);
  localparam logic [CNT_W-1:0] K_SAMPLE = CNT_W'(SAMPLE_CYC);
  localparam logic [CNT_W-1:0] K_TIMEOUT = CNT_W'(TIMEOUT_CYC);

  typedef enum logic [4:0] {
    H_IDLE = 5'b00001,
    H_BREAK = 5'b00010,
    H_RECOV = 5'b00100,
    H_SEND = 5'b01000,
    H_RECV = 5'b10000
  } host_state_e;

  host_state_e st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d, tcnt_q, tcnt_d;
  logic [2:0] nbit_q, nbit_d;
  logic [BYTE_W-1:0] sh_q, sh_d, wdat_q, wdat_d, rdat_q, rdat_d;
  logic two_q, two_d, rd_q, rd_d, arm_q, arm_d, drv_q, drv_d;
  logic rdy_q, rdy_d, rdv_q, rdv_d, to_q, to_d;
  logic s1_q, s2_q, prev_q, fall;

  // ==========================================================
  // line synchroniser and edge detect
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      prev_q <= 1'b1;
    end
    else
    begin
      s1_q <= link.line;
      s2_q <= s1_q;
      prev_q <= s2_q;
    end
  end

  assign fall = prev_q && !s2_q;

  // ==========================================================
  // transaction engine
  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    nbit_d = nbit_q;
    sh_d = sh_q;
    wdat_d = wdat_q;
    rdat_d = rdat_q;
    two_d = two_q;
    rd_d = rd_q;
    arm_d = arm_q;
    drv_d = 1'b0;
    rdy_d = 1'b0;
    rdv_d = 1'b0;
    to_d = 1'b0;
    tcnt_d = (tcnt_q < K_TURN) ? tcnt_q + 1'b1 : tcnt_q;
    case (st_q)
      H_IDLE:
      begin
        rdy_d = (tcnt_q >= K_TURN);
        if (req_valid && rdy_q)
        begin
          rdy_d = 1'b0;
          st_d = H_BREAK;
          cnt_d = '0;
          sh_d = req_cmd;
          wdat_d = req_wdata;
          two_d = req_cmd[WRITE_FLAG_BIT];
          rd_d = !req_cmd[WRITE_FLAG_BIT];
          drv_d = 1'b1;
        end
      end
      H_BREAK:
      begin
        cnt_d = cnt_q + 1'b1;
        drv_d = (cnt_q != K_BREAK);
        if (cnt_q == K_BREAK)
        begin
          st_d = H_RECOV;
          cnt_d = '0;
        end
      end
      H_RECOV:
      begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == K_RECOV)
        begin
          st_d = H_SEND;
          cnt_d = '0;
          nbit_d = '0;
          drv_d = 1'b1;
        end
      end
      H_SEND:
      begin
        cnt_d = cnt_q + 1'b1;
        drv_d = (cnt_q + 1'b1) < (sh_q[0] ? K_ONE : K_ZERO);
        if (cnt_q == K_PERIOD)
        begin
          cnt_d = '0;
          sh_d = {1'b0, sh_q[BYTE_W-1:1]};
          nbit_d = nbit_q + 1'b1;
          drv_d = 1'b1;
          if (nbit_q == 3'd6)
          begin
            tcnt_d = '0;
          end
          if (nbit_q == 3'd7)
          begin
            if (two_q)
            begin
              two_d = 1'b0;
              sh_d = wdat_q;
            end
            else
            begin
              drv_d = 1'b0;
              st_d = rd_q ? H_RECV : H_IDLE;
              arm_d = 1'b0;
            end
          end
        end
      end
      H_RECV:
      begin
        if (fall)
        begin
          cnt_d = '0;
          arm_d = 1'b1;
          if (nbit_q == 3'd7)
          begin
            tcnt_d = '0;
          end
        end
        else
        begin
          cnt_d = cnt_q + 1'b1;
        end
        if (arm_q && cnt_q == K_SAMPLE)
        begin
          arm_d = 1'b0;
          rdat_d = {s2_q, rdat_q[BYTE_W-1:1]};
          nbit_d = nbit_q + 1'b1;
          if (nbit_q == 3'd7)
          begin
            rdv_d = 1'b1;
            st_d = H_IDLE;
          end
        end
        else if (cnt_q == K_TIMEOUT)
        begin
          to_d = 1'b1;
          st_d = H_IDLE;
        end
      end
      default:
      begin
        st_d = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      st_q <= H_IDLE;
      cnt_q <= '0;
      tcnt_q <= K_TURN;
      nbit_q <= '0;
      sh_q <= '0;
      wdat_q <= '0;
      rdat_q <= '0;
      two_q <= 1'b0;
      rd_q <= 1'b0;
      arm_q <= 1'b0;
      drv_q <= 1'b0;
      rdy_q <= 1'b0;
      rdv_q <= 1'b0;
      to_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      tcnt_q <= tcnt_d;
      nbit_q <= nbit_d;
      sh_q <= sh_d;
      wdat_q <= wdat_d;
      rdat_q <= rdat_d;
      two_q <= two_d;
      rd_q <= rd_d;
      arm_q <= arm_d;
      drv_q <= drv_d;
      rdy_q <= rdy_d;
      rdv_q <= rdv_d;
      to_q <= to_d;
    end
  end

  assign link.host_o = 1'b0;
  assign link.host_oe = drv_q;
  assign req_ready = rdy_q;
  assign rd_valid = rdv_q;
  assign rd_data = rdat_q;
  assign rd_timeout = to_q;
endmodule
`default_nettype wire

// ===== tb/swl_link_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module swl_link_assertions #(
  parameter int H1 = 5,
  parameter int H0 = 20,
  parameter int BR = 40,
  parameter int RC = 10,
  parameter int HP = 40,
  parameter int TURN = 45,
  parameter int D1 = 5,
  parameter int D0 = 20,
  parameter int DP = 42,
  parameter int RESP = 60,
  parameter int SAMP = 10
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic host_o,
  input wire logic host_oe,
  input wire logic dev_o,
  input wire logic dev_oe,
  input wire logic line
);
  // ==========================================================
  // low widths and gaps between falling edges, in cycles
  logic [15:0] lh_q, lh_d, ld_q, ld_d, gh_q, gh_d, gd_q, gd_d, pre_q, pre_d;
  logic [2:0] bits_q, bits_d;
  logic hp_q, dp_q, brk_q, brk_d, rise_h, rise_d;

  always_comb
  begin
    rise_h = host_oe & ~hp_q;
    rise_d = dev_oe & ~dp_q;
    lh_d = host_oe ? lh_q + 16'h1 : 16'h0;
    ld_d = dev_oe ? ld_q + 16'h1 : 16'h0;
    gh_d = rise_h ? 16'h1 : gh_q + {15'h0, gh_q != 16'hFFFF};
    gd_d = rise_d ? 16'h1 : gd_q + {15'h0, gd_q != 16'hFFFF};
    pre_d = rise_h ? ((gh_q < gd_q) ? gh_q : gd_q) : pre_q;
    brk_d = (~host_oe & hp_q & (lh_q >= BR)) | (brk_q & ~rise_h);
    bits_d = bits_q + {2'h0, rise_d};
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      {lh_q, ld_q, pre_q} <= '0;
      {gh_q, gd_q} <= '1;
      {bits_q, hp_q, dp_q, brk_q} <= '0;
    end
    else
    begin
      {lh_q, ld_q, gh_q, gd_q, pre_q} <= {lh_d, ld_d, gh_d, gd_d, pre_d};
      {bits_q, hp_q, dp_q, brk_q} <= {bits_d, host_oe, dev_oe, brk_d};
    end
  end

  // ==========================================================
  // properties
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  sequence s_brk_end;
    $fell(host_oe) && (lh_q >= BR);
  endsequence
  property p_host_len;
    $fell(host_oe) |-> (lh_q == H1 || lh_q == H0 || lh_q == BR);
  endproperty
  property p_host_period;
    $rose(host_oe) |-> gh_q >= HP;
  endproperty
  property p_recovery;
    ($rose(host_oe) && brk_q) |-> gh_q == BR + RC;
  endproperty
  property p_turn;
    s_brk_end |-> pre_q >= TURN;
  endproperty
  property p_dev_len;
    $fell(dev_oe) |-> (ld_q == D1 || ld_q == D0);
  endproperty
  property p_dev_period;
    ($rose(dev_oe) && bits_q != 3'h0) |-> gd_q == DP;
  endproperty
  property p_reply;
    ($rose(dev_oe) && bits_q == 3'h0) |-> (gh_q >= RESP + SAMP && gh_q <= RESP + SAMP + 4);
  endproperty
  property p_drive_low;
    !host_o && !dev_o && !(host_oe && dev_oe);
  endproperty

  a_host_len: assert property (p_host_len)
    else $error("host low width off");
  a_host_period: assert property (p_host_period)
    else $error("host bit period short");
  a_recovery: assert property (p_recovery)
    else $error("break recovery off");
  a_turn: assert property (p_turn)
    else $error("turnaround short");
  a_dev_len: assert property (p_dev_len)
    else $error("device low width off");
  a_dev_period: assert property (p_dev_period)
    else $error("device bit period off");
  a_reply: assert property (p_reply)
    else $error("reply delay off");
  a_drive_low: assert property (p_drive_low)
    else $error("both ends pull the line at once");
endmodule
`default_nettype wire

// ===== tb/one_wire_host_bit_timing_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module one_wire_host_bit_timing_tb_top;
  import swl_pkg::*;
  localparam int H1 = 5;
  localparam int H0 = 20;
  localparam int BR = 40;
  localparam int RC = 10;
  localparam int HP = 40;
  localparam int TURN = 45;
  localparam int D1 = 5;
  localparam int D0 = 20;
  localparam int DP = 42;
  localparam int RESP = 60;
  localparam int SAMP = 10;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0;
  logic rx_ready = 1'b0;
  logic [BYTE_W-1:0] req_cmd = 8'h00;
  logic [BYTE_W-1:0] req_wdata = 8'h00;
  logic [BYTE_W-1:0] resp_byte = 8'h00;
  logic [BYTE_W-1:0] wire_byte = 8'h00;
  logic [BYTE_W-1:0] rd_data;
  logic [RX_W-1:0] rx_data;
  logic req_ready, rd_valid, rd_timeout, rx_valid, overrun;
  logic [RX_W-1:0] exp_q[$];
  int fail_count = 0;
  int n_compared = 0;
  int hlen = 0;

  swl_if i_swl_if();
  swl_host #(.PERIOD_CYC(HP), .ONE_CYC(H1), .ZERO_CYC(H0), .BREAK_CYC(BR),
    .RECOVERY_CYC(RC), .TURN_CYC(TURN), .SAMPLE_CYC(SAMP), .TIMEOUT_CYC(120)) i_swl_host (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .link(i_swl_if.host), .req_valid(req_valid),
    .req_ready(req_ready), .req_cmd(req_cmd), .req_wdata(req_wdata), .rd_valid(rd_valid),
    .rd_data(rd_data), .rd_timeout(rd_timeout));
  swl_device #(.PERIOD_CYC(DP), .ONE_CYC(D1), .ZERO_CYC(D0), .RESP_CYC(RESP),
    .SAMPLE_CYC(SAMP), .BREAK_DET_CYC(30)) i_swl_device (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .link(i_swl_if.dev), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data), .resp_byte(resp_byte), .overrun(overrun));
  swl_link_assertions #(.H1(H1), .H0(H0), .BR(BR), .RC(RC), .HP(HP), .TURN(TURN), .D1(D1),
    .D0(D0), .DP(DP), .RESP(RESP), .SAMP(SAMP)) i_swl_link_assertions (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .host_o(i_swl_if.host_o),
    .host_oe(i_swl_if.host_oe), .dev_o(i_swl_if.dev_o), .dev_oe(i_swl_if.dev_oe),
    .line(i_swl_if.line));

  always #(CLK_NS / 2) clk_sys = ~clk_sys;

  // ==========================================================
  // wire monitor: host bits by low width, shifted in lsb first
  always @(negedge clk_sys)
  begin
    if (i_swl_if.host_oe)
      hlen = hlen + 1;
    else if (hlen != 0)
    begin
      if (hlen < BR)
        wire_byte = {hlen < 12, wire_byte[7:1]};
      hlen = 0;
    end
  end

  // ==========================================================
  // tasks
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic request(input logic [7:0] cmd, input logic [7:0] wd, input bit keep);
    int n;
    @(negedge clk_sys);
    req_valid = 1'b1;
    req_cmd = cmd;
    req_wdata = wd;
    for (n = 0; n < 9000 && req_ready !== 1'b1; n++)
      @(negedge clk_sys);
    if (n == 9000)
      fail_count++;
    @(negedge clk_sys);
    req_valid = 1'b0;
    check("req_ready", {8'h00, req_ready}, 9'h000);
    if (keep)
      exp_q.push_back({1'b1, cmd});
    if (keep && cmd[WRITE_FLAG_BIT])
      exp_q.push_back({1'b0, wd});
  endtask

  task automatic pop(input int n);
    int k;
    repeat (n)
    begin
      @(negedge clk_sys);
      for (k = 0; k < 12000 && rx_valid !== 1'b1; k++)
        @(negedge clk_sys);
      if (k == 12000)
        fail_count++;
      check("rx_data", rx_data, exp_q.pop_front());
      rx_ready = 1'b1;
      @(negedge clk_sys);
      rx_ready = 1'b0;
    end
  endtask

  task automatic wait_rd(input logic to, input logic [7:0] exp);
    int k;
    for (k = 0; k < 12000 && rd_valid !== 1'b1 && rd_timeout !== 1'b1; k++)
      @(negedge clk_sys);
    if (k == 12000)
      fail_count++;
    check("rd_timeout", {8'h00, rd_timeout}, {8'h00, to});
    if (!to)
      check("rd_data", {1'b0, rd_data}, {1'b0, exp});
  endtask

  initial
  begin
    #(CLK_NS * 60000);
    fail_count++;
    summarize();
  end

  initial
  begin
    repeat (4) @(negedge clk_sys);
    sys_rst = 1'b0;
    check("line", {8'h00, i_swl_if.line}, 9'h001);
    resp_byte = 8'hA5;
    request(8'h3C, 8'h00, 1'b1);
    wait_rd(1'b0, 8'hA5);
    check("wire_byte", {1'b0, wire_byte}, 9'h03C);
    pop(1);
    $display("test read done");
    // write, then a break must restore command framing
    request(8'h81, 8'h7E, 1'b1);
    resp_byte = 8'h5A;
    request(8'h00, 8'h00, 1'b1);
    wait_rd(1'b0, 8'h5A);
    pop(3);
    $display("test write read done");
    // fill the buffer; the dropped read command is never answered
    for (int i = 0; i < 8; i++)
      request(8'h80 | i[7:0], ~i[7:0], 1'b1);
    request(8'h11, 8'h00, 1'b0);
    wait_rd(1'b1, 8'h00);
    check("overrun", {8'h00, overrun}, 9'h001);
    pop(16);
    @(negedge clk_sys);
    check("rx_valid", {8'h00, rx_valid}, 9'h000);
    $display("test overflow done");
    summarize();
  end
endmodule
`default_nettype wire
